// *** src/breaker_command_control.sv ***
// circuit breaker command control: gated open/close pulses, status filter,
// sync wait, operated pulse and unintended-operation detection
// assumes one 10 MHz clock; the 13 control and status pins are asynchronous and synchronised here, the register port is not
//
// Functional notes
// R1 - local panel requests accepted only while local permission is high
// R2 - remote requests accepted only while remote permission is high
// R3 - close command issued only while sync_ok is high
// R4 - without synchrocheck, surrounding logic ties sync_ok high
// R5 - open command only while open_enable is high
// R6 - close command only while close_enable is high
// R7 - block_operation suppresses all open and close commands
// R8 - breaker supplies separate off and on status contacts
// R9 - external_trip counts as a legitimate cause of a position change
// R10 - accepted open drives one open_command pulse of the set length
// R11 - accepted close drives one close_command pulse of the set length
// R12 - sync_ok false for whole wait time starts synchroswitch when enabled
// R13 - every position change gives a 150 ms operated pulse
// R14 - change without command or external trip sets unintended_operation
// R15 - opened follows the filtered off position
// R16 - closed follows the filtered on position
// R17 - pulse length set in ms, 100 ms after reset
// R18 - sync wait set in ms, 1000 ms after reset, then synchroswitch starts
// R19 - intermediate reported only after outlasting the set wait time
// R20 - failure flagged when position not reached within max operating time
// R21 - position code: intermediate, off, on, bad from the two contacts
// R22 - all timers run from a 1 ms tick and clear on reset
// R23 - new requests ignored while a command pulse is active
`timescale 1ns/1ns
module breaker_command_control #(
   parameter int unsigned TICK_CYCLES = brk_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_b,
   input  wire logic                        local_enable,
   input  wire logic                        remote_enable,
   input  wire logic                        local_open_req,
   input  wire logic                        local_close_req,
   input  wire logic                        remote_open_req,
   input  wire logic                        remote_close_req,
   input  wire logic                        sync_ok,
   input  wire logic                        open_enable,
   input  wire logic                        close_enable,
   input  wire logic                        block_operation,
   input  wire logic                        status_off_in,
   input  wire logic                        status_on_in,
   input  wire logic                        external_trip,
   input  wire logic [brk_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [brk_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [brk_pkg::DATA_W-1:0]  reg_rdata,
   output logic                             open_command,
   output logic                             close_command,
   output logic                             sync_switch_start,
   output logic                             operated,
   output logic                             unintended_operation,
   output logic                             opened,
   output logic                             closed,
   output brk_pkg::pos_t                    position,
   output logic                             operation_failed
);
   import brk_pkg::*;

   localparam int unsigned NIN = 13;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_SYNC,
      ST_PULSE_OPEN,
      ST_PULSE_CLOSE,
      ST_SUPERVISE
   } state_t;

   // true on the tick at which a count started from zero has run len ms
   function automatic logic expired(input logic t, input logic [15:0] cnt,
                                    input logic [15:0] len);
      expired = t && ({1'b0, cnt} + 17'd1 >= {1'b0, len});
   endfunction

   logic [NIN-1:0] pin_in;
   logic [NIN-1:0] meta_q;
   logic [NIN-1:0] sync_q;
   logic           loc_en_s, rem_en_s, loc_open_s, loc_close_s, rem_open_s, rem_close_s;
   logic           sync_ok_s, open_en_s, close_en_s, block_s, off_s, on_s, trip_s;
   logic [3:0]     req_prev_q;
   logic           open_req, close_req, open_acc, close_acc;

   logic           sw_en_q;
   logic [15:0]    pulse_len_q, max_oper_q, max_inter_q, sync_wait_q;
   logic [15:0]    rdata_q;
   logic           clr_wr;

   state_t         state_q;
   pos_t           target_q;
   logic [15:0]    ms_cnt_q;
   logic           tmr_restart, tmr_tick, free_tick;
   logic           open_cmd_q, close_cmd_q, sw_start_q, fail_q;

   pos_t           pos_filt;
   pos_t           last_q;
   logic           last_valid_q, pos_change;
   logic           trip_seen_q, unint_q, oper_q;
   logic [7:0]     oper_cnt_q;

   // each of the 13 control and status pins passes two flip-flops before any logic sees it; the register port does not
   assign pin_in = {local_enable, remote_enable, local_open_req, local_close_req,
                    remote_open_req, remote_close_req, sync_ok, open_enable,
                    close_enable, block_operation, status_off_in, status_on_in,
                    external_trip};

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= pin_in[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   assign {loc_en_s, rem_en_s, loc_open_s, loc_close_s, rem_open_s, rem_close_s,
           sync_ok_s, open_en_s, close_en_s, block_s, off_s, on_s, trip_s} = sync_q;

   // requests act on their rising edge
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_prev_q <= '0;
      end else begin
         req_prev_q <= {loc_open_s, loc_close_s, rem_open_s, rem_close_s};
      end
   end

   assign open_req  = (loc_en_s && loc_open_s && !req_prev_q[3]) || // R1
                      (rem_en_s && rem_open_s && !req_prev_q[1]);   // R2
   assign close_req = (loc_en_s && loc_close_s && !req_prev_q[2]) || // R1
                      (rem_en_s && rem_close_s && !req_prev_q[0]);   // R2

   // open wins over a simultaneous close; only taken when idle
   assign open_acc  = (state_q == ST_IDLE) && open_req && open_en_s && !block_s; // R5 R7 R23
   assign close_acc = (state_q == ST_IDLE) && close_req && !open_acc
                      && close_en_s && !block_s; // R6 R7 R23

   // register writes
   assign clr_wr = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLR_BIT];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_en_q     <= CTRL_SW_EN_RST;
         pulse_len_q <= PULSE_LEN_RST; // R17
         max_oper_q  <= MAX_OPER_RST;
         max_inter_q <= MAX_INTER_RST;
         sync_wait_q <= SYNC_WAIT_RST; // R18
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL:      sw_en_q     <= reg_wdata[CTRL_SW_EN_BIT];
            REG_PULSE_LEN: pulse_len_q <= reg_wdata;
            REG_MAX_OPER:  max_oper_q  <= reg_wdata;
            REG_MAX_INTER: max_inter_q <= reg_wdata;
            REG_SYNC_WAIT: sync_wait_q <= reg_wdata;
            default:       ;
         endcase
      end
   end

   // read data stand in the cycle after the strobe only
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL:      rdata_q <= {15'h0000, sw_en_q};
            REG_PULSE_LEN: rdata_q <= pulse_len_q;
            REG_MAX_OPER:  rdata_q <= max_oper_q;
            REG_MAX_INTER: rdata_q <= max_inter_q;
            REG_SYNC_WAIT: rdata_q <= sync_wait_q;
            REG_STATUS:    rdata_q <= {8'h00, sw_start_q, state_q != ST_IDLE, fail_q,
                                       unint_q, pos_filt == POS_ON, pos_filt == POS_OFF,
                                       pos_filt};
            default:       rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;

   // the command timer restarts its own tick so pulse widths are exact
   assign tmr_restart = open_acc || close_acc ||
                        (state_q == ST_WAIT_SYNC && sync_ok_s && close_en_s && !block_s);

   ms_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_cmd_tick (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .restart (tmr_restart),
      .tick    (tmr_tick)
   );

   ms_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_free_tick (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .restart (1'b0),
      .tick    (free_tick)
   );

   position_filter u_filter (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .off_s     (off_s),
      .on_s      (on_s),
      .tick      (free_tick),
      .max_inter (max_inter_q),
      .pos       (pos_filt),
      .opened    (opened),
      .closed    (closed)
   );

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ms_cnt_q <= '0;
      end else if (tmr_restart) begin
         ms_cnt_q <= '0;
      end else if (tmr_tick && ms_cnt_q != 16'hffff) begin
         ms_cnt_q <= ms_cnt_q + 16'd1; // R22
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q  <= ST_IDLE;
         target_q <= POS_INTER;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (open_acc) begin
                  state_q  <= ST_PULSE_OPEN; // R10
                  target_q <= POS_OFF;
               end else if (close_acc) begin
                  target_q <= POS_ON;
                  state_q  <= sync_ok_s ? ST_PULSE_CLOSE : ST_WAIT_SYNC; // R3
               end
            end
            ST_WAIT_SYNC: begin
               if (block_s || !close_en_s) begin
                  state_q <= ST_IDLE; // R7 R6
               end else if (sync_ok_s) begin
                  state_q <= ST_PULSE_CLOSE; // R3 R11
               end else if (expired(tmr_tick, ms_cnt_q, sync_wait_q)) begin
                  state_q <= ST_IDLE; // R18
               end
            end
            ST_PULSE_OPEN, ST_PULSE_CLOSE: begin
               if (block_s) begin
                  state_q <= ST_IDLE; // R7
               end else if (expired(tmr_tick, ms_cnt_q, pulse_len_q)) begin
                  state_q <= ST_SUPERVISE;
               end
            end
            ST_SUPERVISE: begin
               if (pos_filt == target_q || expired(tmr_tick, ms_cnt_q, max_oper_q)) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // command outputs come from flip-flops; block drops them at once
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         open_cmd_q  <= 1'b0;
         close_cmd_q <= 1'b0;
      end else begin
         open_cmd_q  <= !block_s && (open_acc || (state_q == ST_PULSE_OPEN &&
                        !expired(tmr_tick, ms_cnt_q, pulse_len_q))); // R10 R5 R7
         close_cmd_q <= !block_s && ((close_acc && sync_ok_s) ||
                        (state_q == ST_WAIT_SYNC && sync_ok_s && close_en_s) ||
                        (state_q == ST_PULSE_CLOSE &&
                        !expired(tmr_tick, ms_cnt_q, pulse_len_q))); // R11 R3 R6 R7
      end
   end

   // one-cycle start request once the wait runs out without sync
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_start_q <= 1'b0;
      end else begin
         sw_start_q <= sw_en_q && state_q == ST_WAIT_SYNC && !block_s && close_en_s &&
                       !sync_ok_s && expired(tmr_tick, ms_cnt_q, sync_wait_q); // R12
      end
   end

   // failure stays until the next accepted command; set wins
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fail_q <= 1'b0;
      end else if (state_q == ST_SUPERVISE && pos_filt != target_q &&
                   expired(tmr_tick, ms_cnt_q, max_oper_q)) begin
         fail_q <= 1'b1; // R20
      end else if (open_acc || close_acc) begin
         fail_q <= 1'b0;
      end
   end

   // a change is a move between two settled end positions
   assign pos_change = last_valid_q && (pos_filt == POS_OFF || pos_filt == POS_ON)
                       && pos_filt != last_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         last_q       <= POS_INTER;
         last_valid_q <= 1'b0;
      end else if (pos_filt == POS_OFF || pos_filt == POS_ON) begin
         last_q       <= pos_filt;
         last_valid_q <= 1'b1;
      end
   end

   // a trip stays remembered until the change it explains
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         trip_seen_q <= 1'b0;
      end else if (trip_s) begin
         trip_seen_q <= 1'b1; // R9
      end else if (pos_change) begin
         trip_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         unint_q <= 1'b0;
      end else if (pos_change && state_q == ST_IDLE && !trip_seen_q && !trip_s) begin
         unint_q <= 1'b1; // R14 R9
      end else if (open_acc || close_acc || clr_wr) begin
         unint_q <= 1'b0;
      end
   end

   // operated pulse counts free ticks, so its width may fall short by under 1 ms
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         oper_q     <= 1'b0;
         oper_cnt_q <= '0;
      end else if (pos_change) begin
         oper_q     <= 1'b1; // R13
         oper_cnt_q <= '0;
      end else if (oper_q && free_tick) begin
         if (oper_cnt_q + 8'd1 >= OPER_PULSE_MS) begin
            oper_q <= 1'b0;
         end else begin
            oper_cnt_q <= oper_cnt_q + 8'd1;
         end
      end
   end

   assign open_command         = open_cmd_q;
   assign close_command        = close_cmd_q;
   assign sync_switch_start    = sw_start_q;
   assign operated             = oper_q;
   assign unintended_operation = unint_q;
   assign position             = pos_filt;
   assign operation_failed     = fail_q;

endmodule // breaker_command_control

// *** shared/brk_pkg.sv ***
// constants, types and helpers shared by the breaker command block and its leaves
// assumes a single 10 MHz clock and millisecond-based settings
package brk_pkg;

   // clock and tick timing
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned MS_NS           = 1000000;
   localparam int unsigned TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

   // fixed pulse on the operated output, in ms
   localparam logic [7:0]  OPER_PULSE_MS   = 8'd150;

   // register port geometry
   localparam int unsigned ADDR_W          = 4;
   localparam int unsigned DATA_W          = 16;

   // register offsets
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_PULSE_LEN   = 4'h1;
   localparam logic [3:0]  REG_MAX_OPER    = 4'h2;
   localparam logic [3:0]  REG_MAX_INTER   = 4'h3;
   localparam logic [3:0]  REG_SYNC_WAIT   = 4'h4;
   localparam logic [3:0]  REG_STATUS      = 4'h5;

   // control register fields
   localparam int unsigned CTRL_SW_EN_BIT  = 0;
   localparam int unsigned CTRL_CLR_BIT    = 1;

   // status register fields
   localparam int unsigned ST_POS_LSB      = 0;
   localparam int unsigned ST_OPENED_BIT   = 2;
   localparam int unsigned ST_CLOSED_BIT   = 3;
   localparam int unsigned ST_UNINT_BIT    = 4;
   localparam int unsigned ST_FAIL_BIT     = 5;
   localparam int unsigned ST_BUSY_BIT     = 6;
   localparam int unsigned ST_SW_BIT       = 7;

   // reset values of the settings; the times are in ms
   localparam logic        CTRL_SW_EN_RST  = 1'b0;
   localparam logic [15:0] PULSE_LEN_RST   = 16'd100;
   localparam logic [15:0] MAX_OPER_RST    = 16'd1000;
   localparam logic [15:0] MAX_INTER_RST   = 16'd100;
   localparam logic [15:0] SYNC_WAIT_RST   = 16'd1000;

   typedef enum logic [1:0] {
      POS_INTER,
      POS_OFF,
      POS_ON,
      POS_BAD
   } pos_t;

   function automatic pos_t pos_code(input logic off_in, input logic on_in);
      unique case ({on_in, off_in})
         2'b00:   pos_code = POS_INTER;
         2'b01:   pos_code = POS_OFF;
         2'b10:   pos_code = POS_ON;
         default: pos_code = POS_BAD;
      endcase
   endfunction

endpackage

// *** src/ms_tick.sv ***
// millisecond tick generator with a restart so a timer can align to it
// assumes the clock of the enclosing block
`timescale 1ns/1ns
module ms_tick #(
   parameter int unsigned CYCLES = 10000
) (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic restart,
   output logic      tick
);
   import brk_pkg::*;

   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_q;
   logic         tick_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (restart || cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= (cnt_q == LAST) && !restart;
      end
   end

   assign tick = tick_q;

endmodule // ms_tick

// *** src/position_filter.sv ***
// filters the two breaker contacts into a position code and opened/closed levels
// assumes contacts already synchronised and a free-running ms tick
`timescale 1ns/1ns
module position_filter (
   input  wire logic           ref_clk,
   input  wire logic           rst_b,
   input  wire logic           off_s,
   input  wire logic           on_s,
   input  wire logic           tick,
   input  wire logic [15:0]    max_inter,
   output brk_pkg::pos_t       pos,
   output logic                opened,
   output logic                closed
);
   import brk_pkg::*;

   pos_t        raw;
   pos_t        filt_q;
   logic [15:0] cnt_q;

   assign raw = pos_code(off_s, on_s); // R21

   // an intermediate state is held back until it outlasts the set time
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         filt_q <= POS_INTER;
         cnt_q  <= '0;
      end else if (raw != POS_INTER) begin
         filt_q <= raw;
         cnt_q  <= '0;
      end else if (tick) begin
         if ({1'b0, cnt_q} + 17'd1 >= {1'b0, max_inter}) begin
            filt_q <= POS_INTER; // R19
         end else begin
            cnt_q <= cnt_q + 16'd1;
         end
      end
   end

   assign pos    = filt_q;
   assign opened = (filt_q == POS_OFF); // R15
   assign closed = (filt_q == POS_ON);  // R16

endmodule // position_filter

// *** verif/breaker_command_control_checker.sv ***
// concurrent checks on the breaker command block's top ports
// assumes one clock domain and the asynchronous active-low reset rst_b
`timescale 1ns/1ns
module breaker_command_control_checker #(
   parameter int unsigned TICK_CYCLES = 10
) (
   input logic        ref_clk,
   input logic        rst_b,
   input logic        sync_ok,
   input logic        open_enable,
   input logic        close_enable,
   input logic        block_operation,
   input logic        reg_rd,
   input logic [15:0] reg_rdata,
   input logic        open_command,
   input logic        close_command,
   input logic        sync_switch_start,
   input logic        operated,
   input logic        opened,
   input logic        closed
);
   int unsigned oper_len_q;

   // operated pulse length in cycles
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         oper_len_q <= 0;
      else
         oper_len_q <= operated ? oper_len_q + 1 : 0;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // six cycles cover the input synchronisers
   a_block_stops_cmd: assert property (block_operation [*6] |=>
      !$rose(open_command) && !$rose(close_command)) else $error("command while blocked");
   a_open_needs_en: assert property (!open_enable [*6] |=> !$rose(open_command))
      else $error("open without enable");
   a_close_needs_en: assert property (!close_enable [*6] |=> !$rose(close_command))
      else $error("close without enable");
   a_close_needs_sync: assert property (!sync_ok [*6] |=> !$rose(close_command))
      else $error("close without sync");
   a_cmd_min_width: assert property ($rose(open_command) || $rose(close_command) |=>
      (open_command || close_command) [*8]) else $error("command pulse too short");
   a_cmd_exclusive: assert property (!(open_command && close_command))
      else $error("open and close together");
   a_sw_start_pulse: assert property (sync_switch_start |->
      !close_command ##1 !sync_switch_start) else $error("bad sync switch pulse");
   a_oper_width: assert property ($fell(operated) |->
      oper_len_q >= 149 * TICK_CYCLES && oper_len_q <= 150 * TICK_CYCLES + 1)
      else $error("operated pulse width");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("stray read data");
   a_pos_exclusive: assert property (!(opened && closed))
      else $error("opened and closed together");
endmodule // breaker_command_control_checker

bind breaker_command_control breaker_command_control_checker #(
   .TICK_CYCLES(TICK_CYCLES)
) chk_i (.*);

// *** verif/breaker_model.sv ***
// behavioural breaker: command coils in, two status contacts out
// assumes commands are levels from the control block; travel time in cycles
`timescale 1ns/1ns
module breaker_model #(
   parameter int TRAVEL = 20
) (
   input  logic ref_clk,
   input  logic rst_b,
   input  logic open_command,
   input  logic close_command,
   input  logic stuck,
   input  logic bad,
   input  logic rogue,
   output logic status_off_in,
   output logic status_on_in
);
   logic on_q;
   logic target_q;
   int   t_q;

   // rogue moves the breaker with no command, as a mechanism fault would
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         on_q <= 1'b0;
         target_q <= 1'b0;
         t_q <= 0;
      end else if (t_q != 0) begin
         t_q <= t_q - 1;
         if (t_q == 1)
            on_q <= target_q;
      end else if (rogue || (!stuck && open_command && on_q)
                   || (!stuck && close_command && !on_q)) begin
         target_q <= !on_q;
         t_q <= TRAVEL;
      end
   end

   // both contacts open while travelling
   assign status_off_in = bad || (t_q == 0 && !on_q);
   assign status_on_in  = bad || (t_q == 0 && on_q);
endmodule // breaker_model

// *** verif/tb.sv ***
// self-checking bench for the breaker command block with a breaker model
// assumes TICK_CYCLES of 10, so one millisecond is ten clock cycles
`timescale 1ns/1ns
module tb;
   import brk_pkg::*;
   logic ref_clk = 0, rst_b = 0, sync_ok = 1;
   logic local_enable = 0, remote_enable = 0, open_enable = 1, close_enable = 1;
   logic block_operation = 0, external_trip = 0, reg_wr = 0, reg_rd = 0;
   logic stuck = 0, bad = 0, rogue = 0;
   logic [3:0] req = '0, reg_addr = '0;
   logic [15:0] reg_wdata = '0, reg_rdata, d;
   logic open_command, close_command, sync_switch_start, operated, unintended_operation;
   logic opened, closed, operation_failed, status_off_in, status_on_in;
   pos_t position;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, w = 0, last_w = 0;
   int n_open = 0, n_close = 0, n_sw = 0, n_oper = 0;

   always #50 ref_clk = ~ref_clk;

   breaker_command_control #(.TICK_CYCLES(10)) breaker_command_control_i (.*,
      .local_open_req(req[0]), .local_close_req(req[1]), .remote_open_req(req[2]),
      .remote_close_req(req[3]));
   breaker_model breaker_model_i (.*);

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict;
      end
      w = (open_command || close_command) ? w + 1 : 0;
      if (w != 0) last_w = w;
      if ($rose(open_command)) n_open++;
      if ($rose(close_command)) n_close++;
      if ($rose(sync_switch_start)) n_sw++;
      if ($rose(operated)) n_oper++;
   end

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, lo, hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("wrong value at %0t: count %0d", $time, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   // held five cycles so the synchronised edge is seen
   task automatic pulse_req(input int k);
      @(posedge ref_clk);
      req[k] <= 1;
      repeat (5) @(posedge ref_clk);
      req[k] <= 0;
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 300; i++) begin
         rd(REG_STATUS);
         if (d[ST_BUSY_BIT] === 1'b0) break;
      end
      chk(d[ST_BUSY_BIT], 1'b0);
   endtask

   task automatic s_regs;
      rd(REG_PULSE_LEN);
      chk(d, 16'h0064);
      rd(REG_SYNC_WAIT);
      chk(d, 16'h03e8);
      rd(4'hf);
      chk(d, 16'h0000);
      wr(REG_PULSE_LEN, 16'h0005);
      wr(REG_MAX_OPER, 16'h000a);
      wr(REG_MAX_INTER, 16'h0003);
      wr(REG_SYNC_WAIT, 16'h0004);
      rd(REG_PULSE_LEN);
      chk(d, 16'h0005);
   endtask

   task automatic s_perm;
      int c = n_close;
      chk(opened, 1'b1);
      pulse_req(1);
      local_enable <= 1;
      close_enable <= 0;
      pulse_req(1);
      close_enable <= 1;
      block_operation <= 1;
      pulse_req(1);
      repeat (10) @(posedge ref_clk);
      block_operation <= 0;
      chk_n(n_close - c, 0, 0);
   endtask

   task automatic s_sync;
      int c = n_close, s = n_sw, o = n_oper;
      remote_enable <= 1;
      sync_ok <= 0;
      wr(REG_CTRL, 16'h0001);
      pulse_req(3);
      repeat (60) @(posedge ref_clk);
      chk_n(n_sw - s, 1, 1);
      chk_n(n_close - c, 0, 0);
      pulse_req(3);
      sync_ok <= 1;
      wait_idle;
      chk_n(n_close - c, 1, 1);
      chk_n(last_w, 49, 51);
      repeat (30) @(posedge ref_clk);
      chk(closed, 1'b1);
      chk(position, POS_ON);
      chk_n(n_oper - o, 1, 1);
   endtask

   task automatic s_open;
      int o = n_open, c = n_close;
      open_enable <= 0;
      pulse_req(0);
      repeat (5) @(posedge ref_clk);
      chk_n(n_open - o, 0, 0);
      open_enable <= 1;
      pulse_req(0);
      pulse_req(3);
      wait_idle;
      chk_n(n_open - o, 1, 1);
      chk_n(n_close - c, 0, 0);
      chk_n(last_w, 49, 51);
      repeat (30) @(posedge ref_clk);
      chk(opened, 1'b1);
      chk(closed, 1'b0);
      chk(position, POS_OFF);
   endtask

   // the second self-move happens under an external trip
   task automatic s_unint;
      for (int i = 0; i < 2; i++) begin
         external_trip <= i[0];
         rogue <= 1;
         @(posedge ref_clk);
         rogue <= 0;
         repeat (40) @(posedge ref_clk);
         chk(unintended_operation, !i[0]);
         wr(REG_CTRL, 16'h0003);
      end
      external_trip <= 0;
   endtask

   task automatic s_fail_bad;
      stuck <= 1;
      pulse_req(1);
      wait_idle;
      chk(operation_failed, 1'b1);
      stuck <= 0;
      bad <= 1;
      repeat (10) @(posedge ref_clk);
      chk(position, POS_BAD);
      chk(opened, 1'b0);
      bad <= 0;
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1;
      repeat (40) @(posedge ref_clk);
      s_regs;
      s_perm;
      s_sync;
      s_open;
      s_unint;
      s_fail_bad;
      give_verdict;
   end
endmodule // tb
